// >>> cpu_interrupt_dispatch.sv
// Interrupt classification and dispatch for the CPU core
//
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`include "cpu_interrupt_dispatch_defs.svh"
module cpu_interrupt_dispatch #(
    parameter int AW       = 24,
    parameter int NUM_SRC  = 8,
    parameter int SRC_BASE = 12
) (
    input  wire logic                clk,
    input  wire logic                srst,
    input  wire logic                ce,
    input  wire logic [7:0]          bus_addr,
    input  wire logic [31:0]         bus_wdata,
    input  wire logic                bus_we,
    input  wire logic                bus_re,
    output logic      [31:0]         bus_rdata,
    input  wire logic                instr_valid,
    input  wire cpu_interrupt_dispatch_pkg::instr_kind_type instr_kind,
    input  wire logic [5:0]          instr_num,
    input  wire logic [AW-1:0]       cur_pc,
    input  wire logic                fetch_first,
    input  wire logic [AW-1:0]       fetch_addr,
    input  wire logic                ovf_we,
    input  wire logic                ovf_val,
    input  wire logic [NUM_SRC-1:0]  periph_req,
    input  wire logic                nmi_pin_n,
    input  wire logic                wdt_underflow,
    input  wire logic                osc_stop,
    input  wire logic                lv_cross,
    output logic                     entry_valid,
    output logic      [AW-1:0]       entry_addr,
    output logic                     entry_table,
    output logic                     entry_push,
    output logic      [15:0]         entry_flags,
    output logic      [AW-1:0]       entry_pc,
    output logic                     ret_valid,
    output logic      [AW-1:0]       ret_pc,
    output logic                     ack_valid,
    output logic      [3:0]          ack_src,
    output logic                     dma23_blocked,
    output logic      [15:0]         flags
);
    localparam logic [2:0] FAST_ENTRY_LOAD = 3'(`FAST_ENTRY_CYCLES - 2);
    localparam logic [2:0] FAST_RET_LOAD   = 3'(`FAST_RETURN_CYCLES - 2);

    cpu_interrupt_dispatch_pkg::seq_state_type state_q;

    logic [15:0]         flg_q;
    logic [AW-1:0]       table_base_q;
    logic                fast_en_q;
    logic                dma7_q;
    logic [AW-1:0]       fast_vec_q;
    logic [15:0]         saved_flags_q;
    logic [AW-1:0]       saved_pc_q;
    logic [7:0]          match_en_q;
    logic [2:0]          prio_q [NUM_SRC];
    logic [2:0]          seq_cnt_q;
    logic                nmi_pin_q;
    logic                nmi_pend_q;
    logic                wdt_pend_q;
    logic                match_hit;
    logic [AW-1:0]       match_rd;
    logic [NUM_SRC-1:0]  elig;
    logic [2:0]          processor_priority_level;
    logic                flag_i;

    // Selection results
    logic                sel_take;
    logic [AW-1:0]       sel_addr;
    logic                sel_table;
    logic                sel_clr_u;
    logic                sel_periph;
    logic                sel_fast;
    logic [3:0]          sel_src;
    logic [2:0]          sel_lvl;
    logic                clr_nmi;
    logic                clr_wdt;
    logic                fret_start;

    logic                idle;
    logic                wr_hit;
    logic                wr_match;

    assign processor_priority_level    = flg_q[`FLG_IPL +: 3];
    assign flag_i = flg_q[`FLG_I];
    assign idle   = state_q == cpu_interrupt_dispatch_pkg::ST_IDLE;
    assign wr_hit = ce && bus_we;
    assign wr_match = wr_hit && bus_addr[7:5] == `OFS_MATCH_BASE;

    match_address_bank #(
        .AW (AW),
        .N  (8)
    ) u_match (
        .clk       (clk),
        .srst      (srst),
        .ce        (ce),
        .wr_en     (wr_match),
        .wr_idx    (bus_addr[4:2]),
        .wr_data   (bus_wdata[AW-1:0]),
        .rd_idx    (bus_addr[4:2]),
        .rd_data   (match_rd),
        .cmp_valid (fetch_first),
        .cmp_addr  (fetch_addr),
        .cmp_en    (match_en_q),
        .hit_q     (match_hit)
    );

    // A request counts only above the current processor level
    for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
        assign elig[i] = periph_req[i] && (prio_q[i] > processor_priority_level);
        always_ff @(posedge clk) begin
            if (srst) begin
                prio_q[i] <= 3'h0;
            end else if (wr_hit && bus_addr == `OFS_SRC_PRIO) begin
                prio_q[i] <= bus_wdata[3*i +: 3];
            end
        end
    end

    // Instruction traps, then special events, then address match, then peripherals
    always_comb begin
        sel_take   = 1'b0;
        sel_addr   = '0;
        sel_table  = 1'b1;
        sel_clr_u  = 1'b0;
        sel_periph = 1'b0;
        sel_fast   = 1'b0;
        sel_src    = 4'h0;
        sel_lvl    = 3'h0;
        clr_nmi    = 1'b0;
        clr_wdt    = 1'b0;
        fret_start = 1'b0;
        for (int k = NUM_SRC - 1; k >= 0; k--) begin
            if (elig[k] && prio_q[k] >= sel_lvl) begin
                sel_lvl = prio_q[k];
                sel_src = 4'(k);
            end
        end
        if (instr_valid) begin
            unique case (instr_kind)
                cpu_interrupt_dispatch_pkg::IK_UNDEF: begin
                    sel_take = 1'b1;
                    sel_addr = `VEC_UNDEF;
                end
                cpu_interrupt_dispatch_pkg::IK_OVF: begin
                    sel_take = flg_q[`FLG_O];
                    sel_addr = `VEC_OVF;
                end
                cpu_interrupt_dispatch_pkg::IK_BRK: begin
                    sel_take = 1'b1;
                    sel_addr = `VEC_BRK;
                end
                cpu_interrupt_dispatch_pkg::IK_SWI: begin
                    sel_take  = 1'b1;
                    // Shares the peripheral table slots for the same number
                    sel_addr  = table_base_q + AW'({instr_num, 2'h0});
                    sel_clr_u = ~instr_num[5];
                end
                cpu_interrupt_dispatch_pkg::IK_FRET: begin
                    fret_start = 1'b1;
                end
                // Debug breakpoint has no effect here
                default: begin
                    sel_take = 1'b0;
                end
            endcase
        end else if (nmi_pend_q) begin
            sel_take = 1'b1;
            sel_addr = `VEC_NMI;
            clr_nmi  = 1'b1;
        end else if (wdt_pend_q) begin
            sel_take = 1'b1;
            sel_addr = `VEC_WDT;
            clr_wdt  = 1'b1;
        end else if (match_hit) begin
            sel_take = 1'b1;
            sel_addr = `VEC_MATCH;
        end else if (flag_i && |elig) begin
            sel_periph = 1'b1;
            sel_clr_u  = 1'b1;
            sel_fast   = fast_en_q && sel_lvl == 3'h7;
            sel_take   = ~sel_fast;
            sel_addr   = table_base_q + AW'({6'(SRC_BASE) + 6'(sel_src), 2'h0});
        end
    end

    // Sequencer for the fast path; normal entries finish in one cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            state_q   <= cpu_interrupt_dispatch_pkg::ST_IDLE;
            seq_cnt_q <= 3'h0;
        end else if (ce) begin
            unique case (state_q)
                cpu_interrupt_dispatch_pkg::ST_IDLE: begin
                    if (fret_start) begin
                        state_q   <= cpu_interrupt_dispatch_pkg::ST_FRET;
                        seq_cnt_q <= FAST_RET_LOAD;
                    end else if (sel_fast) begin
                        state_q   <= cpu_interrupt_dispatch_pkg::ST_FENTRY;
                        seq_cnt_q <= FAST_ENTRY_LOAD;
                    end
                end
                cpu_interrupt_dispatch_pkg::ST_FENTRY,
                cpu_interrupt_dispatch_pkg::ST_FRET: begin
                    if (seq_cnt_q == 3'h0) begin
                        state_q <= cpu_interrupt_dispatch_pkg::ST_IDLE;
                    end else begin
                        seq_cnt_q <= seq_cnt_q - 3'h1;
                    end
                end
                default: begin
                    state_q <= cpu_interrupt_dispatch_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Falling edge on the external pin, held until serviced; a new edge beats the clear
    always_ff @(posedge clk) begin
        if (srst) begin
            nmi_pin_q  <= 1'b1;
            nmi_pend_q <= 1'b0;
        end else if (ce) begin
            nmi_pin_q <= nmi_pin_n;
            if (nmi_pin_q && !nmi_pin_n) begin
                nmi_pend_q <= 1'b1;
            end else if (idle && clr_nmi) begin
                nmi_pend_q <= 1'b0;
            end
        end
    end

    // Watchdog, oscillation stop and voltage events share one vector
    always_ff @(posedge clk) begin
        if (srst) begin
            wdt_pend_q <= 1'b0;
        end else if (ce) begin
            if (wdt_underflow || osc_stop || lv_cross) begin
                wdt_pend_q <= 1'b1;
            end else if (idle && clr_wdt) begin
                wdt_pend_q <= 1'b0;
            end
        end
    end

    // Processor flags: hardware updates override a same-cycle software write
    always_ff @(posedge clk) begin
        if (srst) begin
            flg_q <= `FLG_RESET;
        end else if (ce) begin
            if (wr_hit && bus_addr == `OFS_FLAGS) begin
                flg_q <= bus_wdata[15:0];
            end
            if (ovf_we) begin
                flg_q[`FLG_O] <= ovf_val;
            end
            if (idle && (sel_take || sel_fast)) begin
                if (sel_clr_u) begin
                    flg_q[`FLG_U] <= 1'b0;
                end
                // Raising the level stops the same request being taken twice
                if (sel_periph) begin
                    flg_q[`FLG_IPL +: 3] <= sel_lvl;
                end
            end
            if (state_q == cpu_interrupt_dispatch_pkg::ST_FRET && seq_cnt_q == 3'h0) begin
                flg_q <= saved_flags_q;
            end
        end
    end

    // Software-side configuration registers
    always_ff @(posedge clk) begin
        if (srst) begin
            table_base_q <= '0;
            fast_en_q    <= 1'b0;
            dma7_q       <= 1'b0;
            fast_vec_q   <= '0;
            match_en_q   <= 8'h00;
        end else if (wr_hit) begin
            unique case (bus_addr)
                `OFS_TABLE_BASE: table_base_q <= bus_wdata[AW-1:0];
                `OFS_EXIT_LEVEL: begin
                    fast_en_q <= bus_wdata[`EXIT_FAST_EN];
                    dma7_q    <= bus_wdata[`EXIT_DMA7];
                end
                `OFS_FAST_VECTOR: fast_vec_q <= bus_wdata[AW-1:0];
                `OFS_MATCH_EN:    match_en_q <= bus_wdata[7:0];
                default: begin
                    table_base_q <= table_base_q;
                end
            endcase
        end
    end

    // Saved copies for the fast path; these occupy the storage of two DMA channels
    always_ff @(posedge clk) begin
        if (srst) begin
            saved_flags_q <= 16'h0000;
            saved_pc_q    <= '0;
            dma23_blocked <= 1'b0;
        end else if (ce) begin
            dma23_blocked <= fast_en_q;
            if (idle && sel_fast) begin
                saved_flags_q <= flg_q;
                saved_pc_q    <= cur_pc;
            end
        end
    end

    // Entry, return and acknowledge outputs
    always_ff @(posedge clk) begin
        if (srst) begin
            entry_valid <= 1'b0;
            entry_addr  <= '0;
            entry_table <= 1'b0;
            entry_push  <= 1'b0;
            entry_flags <= 16'h0000;
            entry_pc    <= '0;
            ret_valid   <= 1'b0;
            ret_pc      <= '0;
            ack_valid   <= 1'b0;
            ack_src     <= 4'h0;
        end else if (ce) begin
            entry_valid <= 1'b0;
            entry_push  <= 1'b0;
            ret_valid   <= 1'b0;
            ack_valid   <= 1'b0;
            if (idle && sel_take) begin
                entry_valid <= 1'b1;
                entry_addr  <= sel_addr;
                entry_table <= sel_table;
                entry_push  <= 1'b1;
                entry_flags <= flg_q;
                entry_pc    <= cur_pc;
            end
            if (idle && sel_periph) begin
                ack_valid <= 1'b1;
                ack_src   <= sel_src;
            end
            if (state_q == cpu_interrupt_dispatch_pkg::ST_FENTRY && seq_cnt_q == 3'h0) begin
                entry_valid <= 1'b1;
                entry_addr  <= fast_vec_q;
                entry_table <= 1'b0;
                entry_flags <= saved_flags_q;
                entry_pc    <= saved_pc_q;
            end
            if (state_q == cpu_interrupt_dispatch_pkg::ST_FRET && seq_cnt_q == 3'h0) begin
                ret_valid <= 1'b1;
                ret_pc    <= saved_pc_q;
            end
        end
    end

    assign flags = flg_q;

    // Read data stand in the cycle after the strobe; unmapped reads give zero
    always_ff @(posedge clk) begin
        if (srst) begin
            bus_rdata <= 32'h0000_0000;
        end else if (ce) begin
            bus_rdata <= 32'h0000_0000;
            if (bus_re) begin
                if (bus_addr[7:5] == `OFS_MATCH_BASE) begin
                    bus_rdata <= 32'(match_rd);
                end else begin
                    unique case (bus_addr)
                        `OFS_FLAGS:       bus_rdata <= 32'(flg_q);
                        `OFS_TABLE_BASE:  bus_rdata <= 32'(table_base_q);
                        `OFS_EXIT_LEVEL:  bus_rdata <= {30'h0, dma7_q, fast_en_q};
                        `OFS_FAST_VECTOR: bus_rdata <= 32'(fast_vec_q);
                        `OFS_SAVED_FLAGS: bus_rdata <= 32'(saved_flags_q);
                        `OFS_SAVED_PC:    bus_rdata <= 32'(saved_pc_q);
                        `OFS_MATCH_EN:    bus_rdata <= 32'(match_en_q);
                        `OFS_SRC_PRIO: begin
                            for (int k = 0; k < NUM_SRC; k++) begin
                                bus_rdata[3*k +: 3] <= prio_q[k];
                            end
                        end
                        default: bus_rdata <= 32'h0000_0000;
                    endcase
                end
            end
        end
    end
endmodule

// >>> cpu_interrupt_dispatch_defs.svh
// Constants of the interrupt dispatch block
`ifndef CPU_INTERRUPT_DISPATCH_DEFS_SVH
`define CPU_INTERRUPT_DISPATCH_DEFS_SVH

// Register byte offsets; OFS_MATCH_BASE is the value of address bits 7:5 for the match window
`define OFS_FLAGS       8'h00
`define OFS_TABLE_BASE  8'h04
`define OFS_EXIT_LEVEL  8'h08
`define OFS_FAST_VECTOR 8'h0c
`define OFS_SAVED_FLAGS 8'h10
`define OFS_SAVED_PC    8'h14
`define OFS_MATCH_EN    8'h18
`define OFS_SRC_PRIO    8'h1c
`define OFS_MATCH_BASE  3'h1

// Processor flag register fields
`define FLG_O   5
`define FLG_I   6
`define FLG_U   7
`define FLG_IPL 12
`define FLG_RESET 16'h0000

// Exit level register fields
`define EXIT_FAST_EN 0
`define EXIT_DMA7    1

// Fixed vector table locations
`define VEC_UNDEF 24'hffffdc
`define VEC_OVF   24'hffffe0
`define VEC_BRK   24'hffffe4
`define VEC_MATCH 24'hffffe8
`define VEC_WDT   24'hfffff0
`define VEC_NMI   24'hfffff8

// Fast path sequence lengths in cycles
`define FAST_ENTRY_CYCLES  5
`define FAST_RETURN_CYCLES 3

`endif

// >>> cpu_interrupt_dispatch_pkg.sv
// Types shared by the interrupt dispatch block and its users
package cpu_interrupt_dispatch_pkg;

    typedef enum logic [2:0] {
        IK_NONE  = 3'h0,
        IK_UNDEF = 3'h1,
        IK_OVF   = 3'h2,
        IK_BRK   = 3'h3,
        IK_DEBUG_BREAKPOINT_INSTR  = 3'h4,
        IK_SWI   = 3'h5,
        IK_FRET  = 3'h6
    } instr_kind_type;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'h0,
        ST_FENTRY = 2'h1,
        ST_FRET   = 2'h2
    } seq_state_type;

endpackage

// >>> match_address_bank.sv
// Address match store: one compare per channel, registered hit
`timescale 1ns/1ns
module match_address_bank #(
    parameter int AW = 24,
    parameter int N  = 8
) (
    input  wire logic          clk,
    input  wire logic          srst,
    input  wire logic          ce,
    input  wire logic          wr_en,
    input  wire logic [2:0]    wr_idx,
    input  wire logic [AW-1:0] wr_data,
    input  wire logic [2:0]    rd_idx,
    output logic      [AW-1:0] rd_data,
    input  wire logic          cmp_valid,
    input  wire logic [AW-1:0] cmp_addr,
    input  wire logic [N-1:0]  cmp_en,
    output logic               hit_q
);
    logic [AW-1:0] entry_q [N];
    logic [N-1:0]  hit_vec;

    for (genvar i = 0; i < N; i++) begin : g_ch
        always_ff @(posedge clk) begin
            if (srst) begin
                entry_q[i] <= '0;
            end else if (ce && wr_en && wr_idx == 3'(i)) begin
                entry_q[i] <= wr_data;
            end
        end
        assign hit_vec[i] = cmp_en[i] && entry_q[i] == cmp_addr;
    end

    assign rd_data = entry_q[rd_idx];

    // Compare only on the first byte of an instruction
    always_ff @(posedge clk) begin
        if (srst) begin
            hit_q <= 1'b0;
        end else if (ce) begin
            hit_q <= cmp_valid && (|hit_vec);
        end
    end
endmodule

// >>> cpu_interrupt_dispatch_properties.sv
// Port-level temporal checks for the interrupt dispatch block
`timescale 1ns/1ns
`include "cpu_interrupt_dispatch_defs.svh"
module cpu_interrupt_dispatch_properties #(
    parameter int AW = 24
) (
    input wire logic          clk,
    input wire logic          srst,
    input wire logic          ce,
    input wire logic          instr_valid,
    input wire cpu_interrupt_dispatch_pkg::instr_kind_type instr_kind,
    input wire logic [5:0]    instr_num,
    input wire logic          nmi_pin_n,
    input wire logic          entry_valid,
    input wire logic [AW-1:0] entry_addr,
    input wire logic          entry_table,
    input wire logic          entry_push,
    input wire logic          ret_valid,
    input wire logic          ack_valid,
    input wire logic [15:0]   flags
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    wire ins_ok = ce && instr_valid;
    // Fast entry shows nothing for three cycles after the acknowledge
    sequence s_fast_gap; !entry_valid [*3] ##1 entry_valid; endsequence
    sequence s_fret_gap; !ret_valid [*2] ##1 ret_valid; endsequence
    property p_undef;
        ins_ok && instr_kind == cpu_interrupt_dispatch_pkg::IK_UNDEF |=> entry_valid && entry_push
            && entry_addr == `VEC_UNDEF;
    endproperty
    property p_ovf_off;
        ins_ok && instr_kind == cpu_interrupt_dispatch_pkg::IK_OVF && !flags[`FLG_O] |=> !entry_valid;
    endproperty
    property p_brk;
        ins_ok && instr_kind == cpu_interrupt_dispatch_pkg::IK_BRK |=> entry_valid && entry_addr == `VEC_BRK;
    endproperty
    property p_swi_lo;
        ins_ok && instr_kind == cpu_interrupt_dispatch_pkg::IK_SWI && !instr_num[5] |=> entry_valid
            && entry_table && !flags[`FLG_U];
    endproperty
    property p_swi_hi;
        ins_ok && instr_kind == cpu_interrupt_dispatch_pkg::IK_SWI && instr_num[5] |=> entry_valid
            && flags[`FLG_U] == $past(flags[`FLG_U]);
    endproperty
    property p_nmi;
        ce && $fell(nmi_pin_n) |-> ##2 entry_valid && entry_addr == `VEC_NMI;
    endproperty
    property p_fast;
        ce && ack_valid && !entry_valid |=> s_fast_gap ##0 !entry_table && !entry_push;
    endproperty
    property p_fret;
        ins_ok && instr_kind == cpu_interrupt_dispatch_pkg::IK_FRET |=> s_fret_gap;
    endproperty
    property p_mask;
        ack_valid |-> $past(flags[`FLG_I]) && $past(flags[`FLG_IPL +: 3]) != 3'h7;
    endproperty
    a_undef: assert property (p_undef) else $error("undefined trap entry wrong");
    a_ovf_off: assert property (p_ovf_off) else $error("overflow trap taken with flag clear");
    a_brk: assert property (p_brk) else $error("breakpoint entry wrong");
    a_swi_lo: assert property (p_swi_lo) else $error("low software number kept user stack");
    a_swi_hi: assert property (p_swi_hi) else $error("high software number changed stack select");
    a_nmi: assert property (p_nmi) else $error("pin falling edge not dispatched");
    a_fast: assert property (p_fast) else $error("fast entry timing wrong");
    a_fret: assert property (p_fret) else $error("fast return timing wrong");
    a_mask: assert property (p_mask) else $error("request accepted while masked");
endmodule

// >>> periph_request_model.sv
// Peripheral request sources: a request stays up until the dispatcher acknowledges it
`timescale 1ns/1ns
module periph_request_model #(
    parameter int N = 8
) (
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic [N-1:0] raise,
    input  wire logic         ack_valid,
    input  wire logic [3:0]   ack_src,
    output logic      [N-1:0] req_q
);
    always_ff @(posedge clk) begin
        if (srst) begin
            req_q <= '0;
        end else begin
            // Set wins so an event arriving in the acknowledge cycle is not lost
            req_q <= (req_q & ~(N'(ack_valid) << ack_src)) | raise;
        end
    end
endmodule

// >>> cpu_interrupt_dispatch_tb_top.sv
// Self-checking bench for the interrupt dispatch block
`timescale 1ns/1ns
`include "cpu_interrupt_dispatch_defs.svh"
module cpu_interrupt_dispatch_tb_top;
    localparam logic [23:0] BASE = 24'h004000;
    localparam logic [23:0] PC = 24'h00a5a4;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        ce = 1'b1;
    logic [7:0]  bus_addr = 8'h00;
    logic [31:0] bus_wdata = 32'h0;
    logic        bus_we = 1'b0, bus_re = 1'b0, instr_valid = 1'b0, fetch_first = 1'b0;
    logic        ovf_we = 1'b0, ovf_val = 1'b0, nmi_pin_n = 1'b1;
    logic        wdt_underflow = 1'b0, osc_stop = 1'b0, lv_cross = 1'b0;
    cpu_interrupt_dispatch_pkg::instr_kind_type instr_kind = cpu_interrupt_dispatch_pkg::IK_NONE;
    logic [5:0]  instr_num = 6'h00;
    logic [23:0] cur_pc = 24'h0, fetch_addr = 24'h0, entry_addr, entry_pc, ret_pc;
    logic [7:0]  raise = 8'h00, periph_req;
    logic [31:0] bus_rdata;
    logic [15:0] entry_flags, flags;
    logic [3:0]  ack_src;
    logic        entry_valid, entry_table, entry_push, ret_valid, ack_valid, dma23_blocked;
    int          num_errors = 0;
    int          n_checks = 0;
    always #25 clk = ~clk;
    cpu_interrupt_dispatch i_cpu_interrupt_dispatch (.*);
    periph_request_model i_periph_request_model (.clk(clk), .srst(srst), .raise(raise),
        .ack_valid(ack_valid), .ack_src(ack_src), .req_q(periph_req));
    task automatic close_out();
        if (num_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_we <= 1'b1;
        @(posedge clk);
        bus_we <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        bus_addr <= a;
        bus_re <= 1'b1;
        @(posedge clk);
        bus_re <= 1'b0;
        @(negedge clk);
        chk(bus_rdata, exp);
    endtask
    task automatic ins(input cpu_interrupt_dispatch_pkg::instr_kind_type k, input logic [5:0] n);
        @(posedge clk);
        instr_valid <= 1'b1;
        instr_kind <= k;
        instr_num <= n;
        @(posedge clk);
        instr_valid <= 1'b0;
    endtask
    task automatic see_entry(input logic [23:0] a);
        int i = 0;
        do begin
            @(negedge clk);
            i++;
        end while (entry_valid !== 1'b1 && i < 12);
        chk(entry_valid, 1'b1);
        chk(entry_addr, a);
    endtask
    task automatic no_entry();
        repeat (4) begin
            @(negedge clk);
            chk(entry_valid, 1'b0);
        end
    endtask
    task automatic pulse_src(input int k);
        @(posedge clk);
        raise <= 8'(1) << k;
        @(posedge clk);
        raise <= 8'h00;
    endtask
    task automatic fetch(input logic [23:0] a, input logic first);
        @(posedge clk);
        fetch_addr <= a;
        fetch_first <= first;
        @(posedge clk);
        fetch_first <= 1'b0;
    endtask
    task automatic t_regs();
        rd(`OFS_FLAGS, 32'h0);
        wr(`OFS_TABLE_BASE, 32'(BASE));
        rd(`OFS_TABLE_BASE, 32'(BASE));
        @(posedge clk);
        ce <= 1'b0;
        wr(`OFS_TABLE_BASE, 32'h0);
        ce <= 1'b1;
        rd(`OFS_TABLE_BASE, 32'(BASE));
        wr(`OFS_SAVED_PC, 32'h1234);
        rd(`OFS_SAVED_PC, 32'h0);
        rd(8'h40, 32'h0);
    endtask
    task automatic t_soft();
        ins(cpu_interrupt_dispatch_pkg::IK_UNDEF, 6'h00);
        see_entry(`VEC_UNDEF);
        ins(cpu_interrupt_dispatch_pkg::IK_BRK, 6'h00);
        see_entry(`VEC_BRK);
        ins(cpu_interrupt_dispatch_pkg::IK_DEBUG_BREAKPOINT_INSTR, 6'h00);
        no_entry();
        ins(cpu_interrupt_dispatch_pkg::IK_OVF, 6'h00);
        no_entry();
        @(posedge clk);
        ovf_we <= 1'b1;
        ovf_val <= 1'b1;
        @(posedge clk);
        ovf_we <= 1'b0;
        ins(cpu_interrupt_dispatch_pkg::IK_OVF, 6'h00);
        see_entry(`VEC_OVF);
        for (int n = 0; n < 64; n++) begin
            wr(`OFS_FLAGS, 32'h0080);
            ins(cpu_interrupt_dispatch_pkg::IK_SWI, 6'(n));
            see_entry(BASE + 24'(4 * n));
            chk(flags[`FLG_U], n >= 32);
            chk({entry_push, entry_flags, entry_pc}, {1'b1, 16'h0080, PC});
        end
    endtask
    task automatic t_periph();
        wr(`OFS_SRC_PRIO, 32'h3);
        wr(`OFS_FLAGS, 32'h0000);
        pulse_src(0);
        no_entry();
        wr(`OFS_FLAGS, 32'h30c0);
        no_entry();
        wr(`OFS_FLAGS, 32'h20c0);
        see_entry(BASE + 24'd48);
        chk({ack_valid, ack_src, entry_push}, {1'b1, 4'h0, 1'b1});
        chk({flags[`FLG_U], flags[`FLG_IPL +: 3]}, {1'b0, 3'h3});
        wr(`OFS_SRC_PRIO, 32'h7);
        wr(`OFS_FLAGS, 32'h70c0);
        pulse_src(0);
        no_entry();
        wr(`OFS_FLAGS, 32'h00c0);
        see_entry(BASE + 24'd48);
        chk(entry_table, 1'b1);
    endtask
    task automatic t_special();
        // Mask everything so only non-maskable sources can enter
        wr(`OFS_FLAGS, 32'h7000);
        @(posedge clk);
        nmi_pin_n <= 1'b0;
        see_entry(`VEC_NMI);
        no_entry();
        @(posedge clk);
        nmi_pin_n <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            @(posedge clk);
            {lv_cross, osc_stop, wdt_underflow} <= 3'(1) << k;
            @(posedge clk);
            {lv_cross, osc_stop, wdt_underflow} <= 3'h0;
            see_entry(`VEC_WDT);
        end
    endtask
    task automatic t_match();
        for (int k = 0; k < 8; k++) begin
            wr(8'h20 + 8'(4 * k), 32'h2400 + 32'(k));
            wr(`OFS_MATCH_EN, 32'(1) << k);
            fetch(24'h2400 + 24'(k), 1'b0);
            no_entry();
            fetch(24'h2400 + 24'(k), 1'b1);
            see_entry(`VEC_MATCH);
        end
        wr(`OFS_MATCH_EN, 32'h0);
        fetch(24'h2407, 1'b1);
        no_entry();
    endtask
    task automatic t_fast();
        wr(`OFS_SRC_PRIO, 32'h1c0);
        wr(`OFS_EXIT_LEVEL, 32'h1);
        wr(`OFS_FAST_VECTOR, 32'h00abc0);
        wr(`OFS_FLAGS, 32'h00e0);
        pulse_src(2);
        see_entry(24'h00abc0);
        chk({entry_table, entry_push, dma23_blocked}, 3'h1);
        rd(`OFS_SAVED_FLAGS, 32'h00e0);
        rd(`OFS_SAVED_PC, 32'(PC));
        wr(`OFS_FLAGS, 32'h7000);
        ins(cpu_interrupt_dispatch_pkg::IK_FRET, 6'h00);
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk({ret_valid, ret_pc}, {1'b1, PC});
        chk(flags, 16'h00e0);
        wr(`OFS_EXIT_LEVEL, 32'h0);
        rd(`OFS_EXIT_LEVEL, 32'h0);
        chk(dma23_blocked, 1'b0);
    endtask
    initial begin
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        cur_pc <= PC;
        t_regs();
        t_soft();
        t_periph();
        t_special();
        t_match();
        t_fast();
        close_out();
    end
    initial begin
        // Far beyond the few hundred cycles the sequence needs
        #(50 * 20000);
        num_errors++;
        close_out();
    end
endmodule
bind cpu_interrupt_dispatch cpu_interrupt_dispatch_properties #(.AW(AW)) i_cpu_interrupt_dispatch_properties (.*);
